// ---- common/apd_defines.vh ----
`ifndef APD_DEFINES_VH
`define APD_DEFINES_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define APD_ADDR_W 8
`define APD_OFF_FRONT_CTRL 8'h00
`define APD_OFF_FRONT_CHAN 8'h04
`define APD_OFF_CONV_CTRL 8'h08
`define APD_OFF_CONV_ANA 8'h0C
`define APD_OFF_CONV_DIG 8'h10
`define APD_OFF_LANE_OFF 8'h14
`define APD_OFF_STATUS 8'h18

// ****************************************************************
// field positions
// ****************************************************************
// front control register
`define APD_FC_GLOBAL 0
`define APD_FC_QUICK 1
`define APD_FC_PREAMP 2
`define APD_FC_LOWPASS 3
`define APD_FC_W 4
// converter control register
`define APD_CC_GLOBAL 0
`define APD_CC_SERDIS 1
`define APD_CC_W 2
// status register
`define APD_ST_GPIN 0
`define APD_ST_QPIN 1
`define APD_ST_FREF 2
`define APD_ST_PHASE 3
`define APD_ST_TGC 4
`define APD_ST_CREF 5
`define APD_ST_PLL 6
`define APD_ST_FCLK 7
`define APD_ST_W 8

// ****************************************************************
// reset values: everything powered up
// ****************************************************************
`define APD_RST_FC 4'h0
`define APD_RST_CC 2'h0
`define APD_RST_CHAN 16'h0000
`define APD_RST_DATA 32'h0000_0000

`endif

// ---- hw/apd_sync2.v ----
`timescale 1ns/1ns

// ****************************************************************
// two-stage synchroniser for asynchronous pin levels
// ****************************************************************
module apd_sync2 #(
    parameter WIDTH = 2
) (
    input wire clk_sys_in,
    input wire rst_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff; // first stage, read only by stage two
    reg [WIDTH-1:0] sync_ff; // second stage, safe for logic

    // both stages clear to zero, meaning no power-down requested
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // apd_sync2

// ---- hw/apd_ctrl.v ----
`timescale 1ns/1ns
`include "apd_defines.vh"

module apd_ctrl #(
    parameter NCH = 16
) (
    input wire clk_sys_in,
    input wire rst_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [`APD_ADDR_W-1:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [3:0] pstrb_in,
    output wire pready_out,
    output wire pslverr_out,
    output wire [31:0] prdata_out,
    // board power-down pins, active high, asynchronous
    input wire global_shutdown_pin_in,
    input wire quick_sleep_pin_in,
    // front end section enables, high = powered down
    output wire [NCH-1:0] fe_preamp_pd_out,
    output wire [NCH-1:0] fe_lowpass_pd_out,
    output wire [NCH-1:0] fe_mixer_pd_out,
    output wire [NCH-1:0] fe_xpoint_pd_out,
    output wire fe_ref_pd_out,
    output wire fe_phase_pd_out,
    output wire fe_tgc_pd_out,
    // front end blocks that never power down, high = powered up
    output wire fe_bandgap_on_out,
    output wire fe_serial_if_on_out,
    output wire [NCH-1:0] fe_atten_on_out,
    // converter section enables, high = powered down
    output wire [NCH-1:0] cv_analog_pd_out,
    output wire [NCH-1:0] cv_digital_pd_out,
    output wire [NCH-1:0] cv_lane_pd_out,
    output wire cv_fclk_pd_out,
    output wire cv_refclk_pd_out,
    output wire cv_pll_pd_out,
    // converter blocks that never power down
    output wire cv_bandgap_on_out,
    output wire cv_serial_if_on_out
);

    // ****************************************************************
    // functions
    // ****************************************************************

    // byte-lane merge of a write into a stored word
    function [31:0] apd_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer i;
        begin
            apd_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    apd_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // true when the address names a mapped register
    function apd_mapped;
        input [`APD_ADDR_W-1:0] addr;
        begin
            case (addr)
                `APD_OFF_FRONT_CTRL: apd_mapped = 1'b1;
                `APD_OFF_FRONT_CHAN: apd_mapped = 1'b1;
                `APD_OFF_CONV_CTRL: apd_mapped = 1'b1;
                `APD_OFF_CONV_ANA: apd_mapped = 1'b1;
                `APD_OFF_CONV_DIG: apd_mapped = 1'b1;
                `APD_OFF_LANE_OFF: apd_mapped = 1'b1;
                `APD_OFF_STATUS: apd_mapped = 1'b1;
                default: apd_mapped = 1'b0;
            endcase
        end
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    wire [1:0] pin_sync; // {quick, global} after two flip-flops

    // pins are board levels with no relation to our clock
    apd_sync2 #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .async_in({quick_sleep_pin_in, global_shutdown_pin_in}),
        .sync_out(pin_sync)
    );

    wire gpin = pin_sync[0]; // synchronised global shutdown pin
    wire qpin = pin_sync[1]; // synchronised quick sleep pin

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    reg [`APD_FC_W-1:0] front_ctrl_ff; // global, quick, preamp, lowpass
    reg [NCH-1:0] front_channel_off_bits_ff; // per channel front off
    reg [`APD_CC_W-1:0] conv_ctrl_ff; // global, serial disable
    reg [NCH-1:0] conv_analog_channel_off_ff; // per channel analog off
    reg [NCH-1:0] conv_digital_channel_off_ff; // per channel digital off
    reg [NCH-1:0] lane_serializer_off_ff; // per lane serializer off
    reg [31:0] prdata_ff; // read data captured in setup phase
    wire [31:0] wr_word; // write data merged over the addressed stored word

    wire setup_ph = psel_in & ~penable_in; // first cycle of a transfer
    wire access_ph = psel_in & penable_in; // completing cycle
    wire wr_en = access_ph & pwrite_in & apd_mapped(paddr_in); // write strobe

    // decoded register bits
    wire front_global_off_bit = front_ctrl_ff[`APD_FC_GLOBAL];
    wire front_quick_sleep_bit = front_ctrl_ff[`APD_FC_QUICK];
    wire preamp_off_bit = front_ctrl_ff[`APD_FC_PREAMP];
    wire lowpass_off_bit = front_ctrl_ff[`APD_FC_LOWPASS];
    wire conv_global_off_bit = conv_ctrl_ff[`APD_CC_GLOBAL];
    wire serial_out_disable_bit = conv_ctrl_ff[`APD_CC_SERDIS];

    // ****************************************************************
    // register writes, taken at the completing apb edge only
    // ****************************************************************
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            front_ctrl_ff <= `APD_RST_FC;
            front_channel_off_bits_ff <= `APD_RST_CHAN;
            conv_ctrl_ff <= `APD_RST_CC;
            conv_analog_channel_off_ff <= `APD_RST_CHAN;
            conv_digital_channel_off_ff <= `APD_RST_CHAN;
            lane_serializer_off_ff <= `APD_RST_CHAN;
        end else if (wr_en) begin
            case (paddr_in)
                // bits written here power down alongside the pins
                `APD_OFF_FRONT_CTRL: begin
                    front_ctrl_ff <= wr_word[`APD_FC_W-1:0];
                end
                `APD_OFF_FRONT_CHAN: begin
                    front_channel_off_bits_ff <= wr_word[NCH-1:0];
                end
                `APD_OFF_CONV_CTRL: begin
                    conv_ctrl_ff <= wr_word[`APD_CC_W-1:0];
                end
                `APD_OFF_CONV_ANA: begin
                    conv_analog_channel_off_ff <= wr_word[NCH-1:0];
                end
                `APD_OFF_CONV_DIG: begin
                    conv_digital_channel_off_ff <= wr_word[NCH-1:0];
                end
                `APD_OFF_LANE_OFF: begin
                    lane_serializer_off_ff <= wr_word[NCH-1:0];
                end
                // status is read only, writes are dropped
                default: begin
                    front_ctrl_ff <= front_ctrl_ff;
                end
            endcase
        end
    end

    // ****************************************************************
    // power-down decode, combinational next values
    // ****************************************************************
    reg [NCH-1:0] nxt_preamp;
    reg [NCH-1:0] nxt_lowpass;
    reg [NCH-1:0] nxt_mixer;
    reg [NCH-1:0] nxt_xpoint;
    reg [NCH-1:0] nxt_analog;
    reg [NCH-1:0] nxt_digital;
    reg [NCH-1:0] nxt_lane;
    reg nxt_fref;
    reg nxt_phase;
    reg nxt_tgc;
    reg nxt_fclk;
    reg nxt_refclk;
    reg nxt_pll;

    wire fe_all = gpin | front_global_off_bit; // front global off
    wire fe_quick = qpin | front_quick_sleep_bit; // pin high or bit set
    wire cv_all = gpin | conv_global_off_bit; // converter global off
    wire cv_quick = qpin; // converter has no quick sleep bit

    // shared blocks: every control that lists a block is ORed
    always @* begin
        nxt_fref = fe_all; // quick sleep leaves reference up
        nxt_phase = fe_all; // quick sleep leaves phase generator up
        nxt_tgc = fe_all | fe_quick;
        nxt_fclk = cv_all | serial_out_disable_bit; // not quick
        nxt_refclk = cv_all; // reference and clock buffer
        nxt_pll = cv_all; // pll keeps running in quick sleep
    end

    // per channel blocks, one slice per channel
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
            // own channel bit only touches this slice
            always @* begin
                nxt_preamp[ch] = fe_all | fe_quick | front_channel_off_bits_ff[ch]
                    | preamp_off_bit;
                nxt_lowpass[ch] = fe_all | fe_quick | front_channel_off_bits_ff[ch]
                    | lowpass_off_bit;
                nxt_mixer[ch] = fe_all | fe_quick | front_channel_off_bits_ff[ch];
                nxt_xpoint[ch] = fe_all | fe_quick | front_channel_off_bits_ff[ch];
                nxt_analog[ch] = cv_all | cv_quick
                    | conv_analog_channel_off_ff[ch];
                nxt_digital[ch] = cv_all | cv_quick
                    | conv_digital_channel_off_ff[ch];
                nxt_lane[ch] = cv_all | cv_quick | serial_out_disable_bit
                    | lane_serializer_off_ff[ch];
            end
        end
    endgenerate

    // ****************************************************************
    // registered power-down enables
    // ****************************************************************
    reg [NCH-1:0] preamp_pd_ff;
    reg [NCH-1:0] lowpass_pd_ff;
    reg [NCH-1:0] mixer_pd_ff;
    reg [NCH-1:0] xpoint_pd_ff;
    reg [NCH-1:0] analog_pd_ff;
    reg [NCH-1:0] digital_pd_ff;
    reg [NCH-1:0] lane_pd_ff;
    reg fref_pd_ff;
    reg phase_pd_ff;
    reg tgc_pd_ff;
    reg fclk_pd_ff;
    reg refclk_pd_ff;
    reg pll_pd_ff;

    // a flop stage keeps decode glitches off the analog enables
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            preamp_pd_ff <= `APD_RST_CHAN;
            lowpass_pd_ff <= `APD_RST_CHAN;
            mixer_pd_ff <= `APD_RST_CHAN;
            xpoint_pd_ff <= `APD_RST_CHAN;
            analog_pd_ff <= `APD_RST_CHAN;
            digital_pd_ff <= `APD_RST_CHAN;
            lane_pd_ff <= `APD_RST_CHAN;
            fref_pd_ff <= 1'b0;
            phase_pd_ff <= 1'b0;
            tgc_pd_ff <= 1'b0;
            fclk_pd_ff <= 1'b0;
            refclk_pd_ff <= 1'b0;
            pll_pd_ff <= 1'b0;
        end else begin
            preamp_pd_ff <= nxt_preamp;
            lowpass_pd_ff <= nxt_lowpass;
            mixer_pd_ff <= nxt_mixer;
            xpoint_pd_ff <= nxt_xpoint;
            analog_pd_ff <= nxt_analog;
            digital_pd_ff <= nxt_digital;
            lane_pd_ff <= nxt_lane;
            fref_pd_ff <= nxt_fref;
            phase_pd_ff <= nxt_phase;
            tgc_pd_ff <= nxt_tgc;
            fclk_pd_ff <= nxt_fclk;
            refclk_pd_ff <= nxt_refclk;
            pll_pd_ff <= nxt_pll;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    reg [31:0] nxt_rdata; // word selected by the address
    wire [`APD_ST_W-1:0] status_word; // live block state

    assign status_word = {fclk_pd_ff, pll_pd_ff, refclk_pd_ff, tgc_pd_ff,
        phase_pd_ff, fref_pd_ff, qpin, gpin};
    // read mux gives the old word for byte merging
    assign wr_word = apd_merge(nxt_rdata, pwdata_in, pstrb_in);

    // narrow registers read with zeros above
    always @* begin
        case (paddr_in)
            `APD_OFF_FRONT_CTRL: nxt_rdata = {{(32-`APD_FC_W){1'b0}}, front_ctrl_ff};
            `APD_OFF_FRONT_CHAN: nxt_rdata = {{(32-NCH){1'b0}}, front_channel_off_bits_ff};
            `APD_OFF_CONV_CTRL: nxt_rdata = {{(32-`APD_CC_W){1'b0}}, conv_ctrl_ff};
            `APD_OFF_CONV_ANA: nxt_rdata = {{(32-NCH){1'b0}}, conv_analog_channel_off_ff};
            `APD_OFF_CONV_DIG: nxt_rdata = {{(32-NCH){1'b0}}, conv_digital_channel_off_ff};
            `APD_OFF_LANE_OFF: nxt_rdata = {{(32-NCH){1'b0}}, lane_serializer_off_ff};
            `APD_OFF_STATUS: nxt_rdata = {{(32-`APD_ST_W){1'b0}}, status_word};
            default: nxt_rdata = `APD_RST_DATA;
        endcase
    end

    // read data is sampled in the setup cycle so it comes from a flop
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_ff <= `APD_RST_DATA;
        end else if (setup_ph) begin
            prdata_ff <= nxt_rdata;
        end
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready_out = 1'b1;
    assign pslverr_out = access_ph & ~apd_mapped(paddr_in);
    assign prdata_out = prdata_ff;

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign fe_preamp_pd_out = preamp_pd_ff;
    assign fe_lowpass_pd_out = lowpass_pd_ff;
    assign fe_mixer_pd_out = mixer_pd_ff;
    assign fe_xpoint_pd_out = xpoint_pd_ff;
    assign fe_ref_pd_out = fref_pd_ff;
    assign fe_phase_pd_out = phase_pd_ff;
    assign fe_tgc_pd_out = tgc_pd_ff;
    assign cv_analog_pd_out = analog_pd_ff;
    assign cv_digital_pd_out = digital_pd_ff;
    assign cv_lane_pd_out = lane_pd_ff;
    assign cv_fclk_pd_out = fclk_pd_ff;
    assign cv_refclk_pd_out = refclk_pd_ff;
    assign cv_pll_pd_out = pll_pd_ff;

    // no control reaches these, they stay on even in reset
    assign fe_bandgap_on_out = 1'b1;
    assign fe_serial_if_on_out = 1'b1;
    assign fe_atten_on_out = {NCH{1'b1}};
    assign cv_bandgap_on_out = 1'b1;
    assign cv_serial_if_on_out = 1'b1;
endmodule // apd_ctrl

// ---- test/apd_ctrl_properties.sv ----
`timescale 1ns/1ns

// ****************************************************************
// port-level checker for the power-down decode block
// ****************************************************************
module apd_ctrl_properties #(
    parameter NCH = 16
) (
    input wire clk_sys_in,
    input wire rst_in,
    input wire global_shutdown_pin_in,
    input wire quick_sleep_pin_in,
    input wire [NCH-1:0] fe_preamp_pd_out,
    input wire [NCH-1:0] fe_lowpass_pd_out,
    input wire [NCH-1:0] fe_mixer_pd_out,
    input wire [NCH-1:0] fe_xpoint_pd_out,
    input wire fe_ref_pd_out,
    input wire fe_phase_pd_out,
    input wire fe_tgc_pd_out,
    input wire fe_bandgap_on_out,
    input wire fe_serial_if_on_out,
    input wire [NCH-1:0] fe_atten_on_out,
    input wire [NCH-1:0] cv_analog_pd_out,
    input wire [NCH-1:0] cv_digital_pd_out,
    input wire [NCH-1:0] cv_lane_pd_out,
    input wire cv_fclk_pd_out,
    input wire cv_refclk_pd_out,
    input wire cv_pll_pd_out,
    input wire cv_bandgap_on_out,
    input wire cv_serial_if_on_out
);
    // one clock domain, so one default clocking and one reset
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    // a pin held for four samples has crossed both sync flops and the output flop
    sequence global_held;
        global_shutdown_pin_in [*4];
    endsequence
    sequence quick_held;
        quick_sleep_pin_in [*4];
    endsequence

    front_always_on_a: assert property (fe_bandgap_on_out && fe_serial_if_on_out && &fe_atten_on_out)
        else $error("front always-on block switched off");
    conv_always_on_a: assert property (cv_bandgap_on_out && cv_serial_if_on_out)
        else $error("converter always-on block switched off");
    global_pin_front_a: assert property (global_held |-> &fe_preamp_pd_out
        && &fe_lowpass_pd_out && &fe_mixer_pd_out && &fe_xpoint_pd_out && fe_ref_pd_out
        && fe_phase_pd_out && fe_tgc_pd_out)
        else $error("shutdown pin left a front block on");
    global_pin_conv_a: assert property (global_held |-> &cv_analog_pd_out
        && &cv_digital_pd_out && &cv_lane_pd_out && cv_fclk_pd_out && cv_refclk_pd_out
        && cv_pll_pd_out)
        else $error("shutdown pin left a converter block on");
    quick_pin_front_a: assert property (quick_held |-> &fe_preamp_pd_out
        && &fe_lowpass_pd_out && &fe_mixer_pd_out && &fe_xpoint_pd_out && fe_tgc_pd_out)
        else $error("quick sleep pin left a front block on");
    quick_pin_conv_a: assert property (quick_held |-> &cv_analog_pd_out
        && &cv_digital_pd_out && &cv_lane_pd_out)
        else $error("quick sleep pin left a converter core on");
    channel_path_union_a: assert property (fe_mixer_pd_out == fe_xpoint_pd_out
        && (fe_mixer_pd_out & ~fe_preamp_pd_out) == '0
        && (fe_mixer_pd_out & ~fe_lowpass_pd_out) == '0)
        else $error("channel path enables disagree");
    front_ref_pair_a: assert property (fe_ref_pd_out == fe_phase_pd_out
        && (!fe_ref_pd_out || (fe_tgc_pd_out && &fe_mixer_pd_out)))
        else $error("reference and phase generator enables disagree");
    serial_dis_lanes_a: assert property (cv_fclk_pd_out |-> &cv_lane_pd_out)
        else $error("frame serializer off with a data lane on");
    conv_global_pair_a: assert property (cv_refclk_pd_out == cv_pll_pd_out
        && (!cv_pll_pd_out || (cv_fclk_pd_out && &cv_analog_pd_out && &cv_digital_pd_out)))
        else $error("converter clock enables disagree");
endmodule // apd_ctrl_properties

bind apd_ctrl apd_ctrl_properties #(.NCH(NCH)) i_apd_ctrl_properties (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .global_shutdown_pin_in(global_shutdown_pin_in), .quick_sleep_pin_in(quick_sleep_pin_in),
    .fe_preamp_pd_out(fe_preamp_pd_out), .fe_lowpass_pd_out(fe_lowpass_pd_out),
    .fe_mixer_pd_out(fe_mixer_pd_out), .fe_xpoint_pd_out(fe_xpoint_pd_out),
    .fe_ref_pd_out(fe_ref_pd_out), .fe_phase_pd_out(fe_phase_pd_out),
    .fe_tgc_pd_out(fe_tgc_pd_out), .fe_bandgap_on_out(fe_bandgap_on_out),
    .fe_serial_if_on_out(fe_serial_if_on_out), .fe_atten_on_out(fe_atten_on_out),
    .cv_analog_pd_out(cv_analog_pd_out), .cv_digital_pd_out(cv_digital_pd_out),
    .cv_lane_pd_out(cv_lane_pd_out), .cv_fclk_pd_out(cv_fclk_pd_out),
    .cv_refclk_pd_out(cv_refclk_pd_out), .cv_pll_pd_out(cv_pll_pd_out),
    .cv_bandgap_on_out(cv_bandgap_on_out), .cv_serial_if_on_out(cv_serial_if_on_out)
);

// ---- test/apd_board_model.sv ----
`timescale 1ns/1ns

// ****************************************************************
// board controller: drives the two power-down pins as levels
// ****************************************************************
module apd_board_model (
    input wire logic clk_sys_in,
    input wire logic want_global_in,
    input wire logic want_quick_in,
    output logic global_shutdown_pin_out,
    output logic quick_sleep_pin_out
);
    // pins start low so the device comes up powered
    initial begin
        global_shutdown_pin_out = 1'b0;
        quick_sleep_pin_out = 1'b0;
    end
    // pins move only just after an edge and then hold as static levels
    always @(posedge clk_sys_in) begin
        global_shutdown_pin_out <= want_global_in;
        quick_sleep_pin_out <= want_quick_in;
    end
endmodule // apd_board_model

// ---- test/apd_ctrl_bench.sv ----
`timescale 1ns/1ns
`include "apd_defines.vh"

module apd_ctrl_bench;
    // ****************************************************************
    // stimulus and observation signals
    // ****************************************************************
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic want_global = 1'b0;
    logic want_quick = 1'b0;
    wire pready, pslverr, gpin, qpin, ref_pd, ph_pd, tgc_pd;
    wire fe_bg, fe_si, fclk, rclk, pll, cv_bg, cv_si;
    wire [31:0] prdata;
    wire [15:0] pre, lp, mx, xp, atn, an, dg, ln;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;

    apd_ctrl #(.NCH(16)) i_apd_ctrl (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
        .global_shutdown_pin_in(gpin), .quick_sleep_pin_in(qpin),
        .fe_preamp_pd_out(pre), .fe_lowpass_pd_out(lp), .fe_mixer_pd_out(mx),
        .fe_xpoint_pd_out(xp), .fe_ref_pd_out(ref_pd), .fe_phase_pd_out(ph_pd),
        .fe_tgc_pd_out(tgc_pd), .fe_bandgap_on_out(fe_bg), .fe_serial_if_on_out(fe_si),
        .fe_atten_on_out(atn), .cv_analog_pd_out(an), .cv_digital_pd_out(dg),
        .cv_lane_pd_out(ln), .cv_fclk_pd_out(fclk), .cv_refclk_pd_out(rclk),
        .cv_pll_pd_out(pll), .cv_bandgap_on_out(cv_bg), .cv_serial_if_on_out(cv_si)
    );
    apd_board_model i_apd_board_model (
        .clk_sys_in(clk_sys_in), .want_global_in(want_global), .want_quick_in(want_quick),
        .global_shutdown_pin_out(gpin), .quick_sleep_pin_out(qpin)
    );

    // ****************************************************************
    // clock, timeout and shared tasks
    // ****************************************************************
    always #4 clk_sys_in = ~clk_sys_in;
    // a hung handshake must not stall the run forever
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer: setup, then access until pready is sampled high
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        @(posedge clk_sys_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do @(posedge clk_sys_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // write, then let the register and the output flop settle
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic e;
        acc(1'b1, a, d, s, r, e);
        repeat (2) @(posedge clk_sys_in);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                          input logic eerr);
        logic [31:0] r;
        logic e;
        acc(1'b0, a, 32'h0000_0000, 4'h0, r, e);
        chk(nm, r, exp);
        chk("slave error", 32'(e), 32'(eerr));
    endtask

    // all decoded enables at once; mixer and cross-point share one expectation
    task automatic chk_all(input logic [15:0] e_pre, e_lp, e_mx, input logic [2:0] e_fe,
                           input logic [15:0] e_an, e_dg, e_ln, input logic [2:0] e_cv);
        chk("preamp", 32'(pre), 32'(e_pre));
        chk("lowpass", 32'(lp), 32'(e_lp));
        chk("mixer", 32'(mx), 32'(e_mx));
        chk("xpoint", 32'(xp), 32'(e_mx));
        chk("ref phase tgc", 32'({ref_pd, ph_pd, tgc_pd}), 32'(e_fe));
        chk("analog", 32'(an), 32'(e_an));
        chk("digital", 32'(dg), 32'(e_dg));
        chk("lane", 32'(ln), 32'(e_ln));
        chk("fclk refclk pll", 32'({fclk, rclk, pll}), 32'(e_cv));
        chk("always on", 32'({fe_bg, fe_si, atn, cv_bg, cv_si}), 32'h000F_FFFF);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_values();
        chk_all('0, '0, '0, 3'h0, '0, '0, '0, 3'h0);
        wr(`APD_OFF_STATUS, 32'hFFFF_FFFF, 4'hF);
        for (int i = 0; i < 7; i++) begin
            rd_chk("reset value", 8'(4 * i), 32'h0000_0000, 1'b0);
        end
        rd_chk("unmapped", 8'h1C, 32'h0000_0000, 1'b1);
    endtask

    task automatic t_front_bits();
        wr(`APD_OFF_FRONT_CTRL, 32'h0000_0001, 4'hF);
        chk_all('1, '1, '1, 3'h7, '0, '0, '0, 3'h0);
        wr(`APD_OFF_FRONT_CTRL, 32'h0000_0002, 4'hF);
        chk_all('1, '1, '1, 3'h1, '0, '0, '0, 3'h0);
        wr(`APD_OFF_FRONT_CTRL, 32'h0000_0004, 4'hF);
        wr(`APD_OFF_FRONT_CHAN, 32'h0000_8001, 4'hF);
        chk_all('1, 16'h8001, 16'h8001, 3'h0, '0, '0, '0, 3'h0);
        wr(`APD_OFF_FRONT_CTRL, 32'h0000_0008, 4'hF);
        chk_all(16'h8001, '1, 16'h8001, 3'h0, '0, '0, '0, 3'h0);
        wr(`APD_OFF_FRONT_CTRL, 32'h0000_0000, 4'hF);
        wr(`APD_OFF_FRONT_CHAN, 32'h0000_0000, 4'hF);
    endtask

    task automatic t_conv_bits();
        wr(`APD_OFF_CONV_CTRL, 32'h0000_0001, 4'hF);
        chk_all('0, '0, '0, 3'h0, '1, '1, '1, 3'h7);
        wr(`APD_OFF_CONV_CTRL, 32'h0000_0002, 4'hF);
        chk_all('0, '0, '0, 3'h0, '0, '0, '1, 3'h4);
        wr(`APD_OFF_CONV_CTRL, 32'h0000_0000, 4'hF);
        wr(`APD_OFF_CONV_ANA, 32'h0000_0002, 4'hF);
        wr(`APD_OFF_CONV_DIG, 32'h0000_0004, 4'hF);
        wr(`APD_OFF_LANE_OFF, 32'h0000_FFFF, 4'h2);
        chk_all('0, '0, '0, 3'h0, 16'h0002, 16'h0004, 16'hFF00, 3'h0);
        rd_chk("lane bits", `APD_OFF_LANE_OFF, 32'h0000_FF00, 1'b0);
        wr(`APD_OFF_CONV_ANA, 32'h0000_0000, 4'hF);
        wr(`APD_OFF_CONV_DIG, 32'h0000_0000, 4'hF);
        wr(`APD_OFF_LANE_OFF, 32'h0000_0000, 4'hF);
    endtask

    // pins take two sync flops plus the output flop before they show
    task automatic t_pins();
        want_quick <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        chk_all('1, '1, '1, 3'h1, '1, '1, '1, 3'h0);
        rd_chk("status quick", `APD_OFF_STATUS, 32'h0000_0012, 1'b0);
        want_quick <= 1'b0;
        want_global <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        chk_all('1, '1, '1, 3'h7, '1, '1, '1, 3'h7);
        rd_chk("status global", `APD_OFF_STATUS, 32'h0000_00FD, 1'b0);
        want_global <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        chk_all('0, '0, '0, 3'h0, '0, '0, '0, 3'h0);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        t_reset_values();
        t_front_bits();
        t_conv_bits();
        t_pins();
        wrap_up();
    end
endmodule // apd_ctrl_bench
